// [logic/eac_cpu_end.sv]
// processor side sequencer driving the nonvolatile access port
`timescale 1ns/1ps
`include "eac_regs.svh"

module eac_cpu_end
  import eac_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [2:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_we,
  input  wire logic       cmd_re,
  output logic      [7:0] cmd_rdata,
  eac_if.cpu              bus
);

  eac_hstate_type state_ff;
  eac_hstate_type nxt_state;
  logic           is_read_ff;
  logic           done_ff;
  logic [7:0]     adrl_ff;
  logic [7:0]     adrh_ff;
  logic [7:0]     wdata_ff;
  logic [7:0]     cfg_ff;
  logic [7:0]     rdata_ff;
  logic [7:0]     cmd_rdata_ff;
  logic [5:0]     io_addr_ff;
  logic [7:0]     io_wdata_ff;
  logic           io_we_ff;
  logic           io_re_ff;
  logic           gie_ff;
  logic [5:0]     nxt_addr;
  logic [7:0]     nxt_wdata;
  logic           nxt_we;
  logic           nxt_re;
  logic           go_wr;
  logic           go_rd;
  logic [3:0]     ctl_keep;

  assign go_wr    = cmd_we && cmd_addr == `EAC_H_CMD && cmd_wdata[`EAC_H_BIT_GO_WR]
                    && state_ff == H_IDLE;
  assign go_rd    = cmd_we && cmd_addr == `EAC_H_CMD && cmd_wdata[`EAC_H_BIT_GO_RD]
                    && state_ff == H_IDLE && !go_wr;
  assign ctl_keep = {cfg_ff[`EAC_BIT_MODE +: 2], cfg_ff[`EAC_BIT_RIE], 1'b0};

  // each state issues its own access; strobe follows arm on the next cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = `EAC_OFS_CTRL;
    nxt_wdata = 8'h00;
    nxt_we    = 1'b0;
    nxt_re    = 1'b0;
    unique case (state_ff)
      H_IDLE: begin
        if (go_wr || go_rd) begin
          nxt_state = H_POLL_RD;
          nxt_re    = 1'b1;
        end
      end
      H_POLL_RD: nxt_state = H_POLL_CHK;
      H_POLL_CHK: begin
        if (bus.io_rdata[`EAC_BIT_WSTROBE] || cfg_ff[`EAC_H_BIT_SELFPROG]) begin
          nxt_state = H_POLL_RD;
          nxt_re    = 1'b1;
        end else begin
          nxt_state = H_ADR_LO;
          nxt_we    = 1'b1;
          nxt_addr  = `EAC_OFS_ADRL;
          nxt_wdata = adrl_ff;
        end
      end
      H_ADR_LO: begin
        nxt_state = is_read_ff ? H_RSTROBE : H_ADR_HI;
        nxt_we    = 1'b1;
        nxt_addr  = is_read_ff ? `EAC_OFS_CTRL : `EAC_OFS_ADRH;
        nxt_wdata = is_read_ff ? {2'b00, ctl_keep, 2'b01} : adrh_ff;
      end
      H_ADR_HI: begin
        nxt_state = H_DATA;
        nxt_we    = 1'b1;
        nxt_addr  = `EAC_OFS_DATA;
        nxt_wdata = wdata_ff;
      end
      H_DATA: begin
        nxt_state = H_ARM;
        nxt_we    = 1'b1;
        nxt_wdata = {2'b00, ctl_keep[3:1], 1'b1, 2'b00};
      end
      H_ARM: begin
        nxt_state = H_FIRE;
        nxt_we    = 1'b1;
        nxt_wdata = {2'b00, ctl_keep[3:1], 1'b1, 2'b10};
      end
      H_FIRE:    nxt_state = H_STALL;
      H_RSTROBE: nxt_state = H_STALL;
      H_STALL: begin
        if (!bus.cpu_stall && is_read_ff) begin
          nxt_state = H_GET;
          nxt_re    = 1'b1;
          nxt_addr  = `EAC_OFS_DATA;
        end else if (!bus.cpu_stall) begin
          nxt_state = H_IDLE;
        end
      end
      H_GET: nxt_state = H_CAP;
      H_CAP: nxt_state = H_IDLE;
      default: nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff    <= H_IDLE;
      io_addr_ff  <= 6'h00;
      io_wdata_ff <= 8'h00;
      io_we_ff    <= 1'b0;
      io_re_ff    <= 1'b0;
      gie_ff      <= 1'b0;
    end else if (clk_en) begin
      state_ff    <= nxt_state;
      io_addr_ff  <= nxt_addr;
      io_wdata_ff <= nxt_wdata;
      io_we_ff    <= nxt_we;
      io_re_ff    <= nxt_re;
      // interrupts held off for the whole sequence
      gie_ff      <= cfg_ff[`EAC_H_BIT_GIE] && nxt_state == H_IDLE;
    end
  end

  // command registers; a finish in the same cycle as a new go leaves done set
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      adrl_ff    <= 8'h00;
      adrh_ff    <= 8'h00;
      wdata_ff   <= 8'h00;
      cfg_ff     <= 8'h00;
      rdata_ff   <= 8'h00;
      is_read_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else if (clk_en) begin
      if (cmd_we && cmd_addr == `EAC_H_ADRL) adrl_ff <= cmd_wdata;
      if (cmd_we && cmd_addr == `EAC_H_ADRH) adrh_ff <= cmd_wdata;
      if (cmd_we && cmd_addr == `EAC_H_WDATA) wdata_ff <= cmd_wdata;
      if (cmd_we && cmd_addr == `EAC_H_CFG) cfg_ff <= cmd_wdata;
      if (go_wr || go_rd) is_read_ff <= go_rd;
      if (state_ff == H_CAP) rdata_ff <= bus.io_rdata;
      if ((state_ff == H_CAP) || (state_ff == H_STALL && nxt_state == H_IDLE)) begin
        done_ff <= 1'b1;
      end else if (go_wr || go_rd) begin
        done_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_rdata_ff <= 8'h00;
    end else if (clk_en) begin
      unique case (cmd_addr)
        `EAC_H_ADRL:   cmd_rdata_ff <= cmd_re ? adrl_ff : 8'h00;
        `EAC_H_ADRH:   cmd_rdata_ff <= cmd_re ? adrh_ff : 8'h00;
        `EAC_H_WDATA:  cmd_rdata_ff <= cmd_re ? wdata_ff : 8'h00;
        `EAC_H_STATUS: cmd_rdata_ff <= cmd_re ? {6'h00, done_ff, state_ff != H_IDLE} : 8'h00;
        `EAC_H_CFG:    cmd_rdata_ff <= cmd_re ? cfg_ff : 8'h00;
        `EAC_H_RDATA:  cmd_rdata_ff <= cmd_re ? rdata_ff : 8'h00;
        default:       cmd_rdata_ff <= 8'h00;
      endcase
    end
  end

  assign cmd_rdata                 = cmd_rdata_ff;
  assign bus.io_addr               = io_addr_ff;
  assign bus.io_wdata              = io_wdata_ff;
  assign bus.io_we                 = io_we_ff;
  assign bus.io_re                 = io_re_ff;
  assign bus.global_irq_enable     = gie_ff;
  assign bus.flash_selfprog_enable = cfg_ff[`EAC_H_BIT_SELFPROG];

endmodule

// [logic/eac_device_end.sv]
// nonvolatile byte access block: control registers, timing and byte array
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "eac_regs.svh"

module eac_device_end
  import eac_pkg::*;
#(
  parameter int ADDR_W          = 10,
  parameter int WRITE_RC_CYCLES = `EAC_WRITE_RC_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic rc_osc_clk,
  output logic      nv_busy,
  eac_if.dev        bus
);

  localparam int HALF_RC_CYCLES = WRITE_RC_CYCLES * `EAC_T_HALF_US / `EAC_T_ATOMIC_US;
  localparam int TW             = $clog2(WRITE_RC_CYCLES + 1);

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0]        mem [0:(1 << ADDR_W) - 1];
  eac_mode_type      mode_ff;
  eac_mode_type      op_mode_ff;
  logic              rie_ff;
  logic [2:0]        arm_cnt_ff;
  logic              busy_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0]        data_ff;
  logic [ADDR_W-1:0] op_addr_ff;
  logic [7:0]        op_data_ff;
  logic [TW-1:0]     rc_timer_ff;
  logic [2:0]        stall_cnt_ff;
  logic [7:0]        rdata_ff;
  logic              rc_s1_ff;
  logic              rc_s2_ff;
  logic              rc_s3_ff;

  logic              ctrl_wr;
  logic              arm_live;
  logic              start_wr;
  logic              start_rd;
  logic              rc_edge;
  logic              wr_done;
  eac_mode_type      wr_mode;
  logic [TW-1:0]     nxt_timer;

  assign ctrl_wr  = bus.io_we && hit(bus.io_addr, `EAC_OFS_CTRL);
  assign arm_live = (arm_cnt_ff != 3'h0);
  assign wr_mode  = eac_mode_type'(bus.io_wdata[`EAC_BIT_MODE +: 2]);

  // reserved action code starts no write rather than guessing an operation
  assign start_wr = ctrl_wr && bus.io_wdata[`EAC_BIT_WSTROBE]
                    && arm_live
                    && !busy_ff
                    && !bus.flash_selfprog_enable
                    && (wr_mode != MODE_RSVD);
  assign start_rd = ctrl_wr && bus.io_wdata[`EAC_BIT_RSTROBE]
                    && !busy_ff && !start_wr;

  // oscillator pin passes three flops; the second and the third feed the edge detect
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end else if (clk_en) begin
      rc_s1_ff <= rc_osc_clk;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end

  assign rc_edge = rc_s2_ff && !rc_s3_ff;
  assign wr_done = busy_ff && rc_edge && (rc_timer_ff == TW'(1));

  // arm window: loaded only by a write with the strobe bit low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      arm_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      if (ctrl_wr && bus.io_wdata[`EAC_BIT_ARM] && !bus.io_wdata[`EAC_BIT_WSTROBE]) begin
        arm_cnt_ff <= `EAC_ARM_CYCLES;
      end else if (start_wr) begin
        arm_cnt_ff <= 3'h0;
      end else if (arm_live) begin
        arm_cnt_ff <= arm_cnt_ff - 3'h1;
      end
    end
  end

  // action field and ready enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_ff <= eac_mode_type'(`EAC_MODE_RST);
      rie_ff  <= `EAC_RIE_RST;
    end else if (clk_en && ctrl_wr) begin
      rie_ff <= bus.io_wdata[`EAC_BIT_RIE];
      if (!busy_ff) begin
        mode_ff <= wr_mode;
      end
    end
  end

  // address and data registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_ff <= '0;
      data_ff <= 8'h00;
    end else if (clk_en) begin
      if (bus.io_we && !busy_ff && hit(bus.io_addr, `EAC_OFS_ADRL)) begin
        addr_ff[7:0] <= bus.io_wdata;
      end
      if (bus.io_we && !busy_ff && hit(bus.io_addr, `EAC_OFS_ADRH)) begin
        addr_ff[ADDR_W-1:8] <= bus.io_wdata[ADDR_W-9:0];
      end
      if (start_rd) begin
        data_ff <= mem[addr_ff];
      end else if (bus.io_we && hit(bus.io_addr, `EAC_OFS_DATA)) begin
        data_ff <= bus.io_wdata;
      end
    end
  end

  // write engine: operands latched at start so later register writes are harmless
  always_comb begin
    nxt_timer = rc_timer_ff;
    if (start_wr) begin
      if (wr_mode == MODE_ATOMIC) begin
        nxt_timer = TW'(WRITE_RC_CYCLES);
      end else begin
        nxt_timer = TW'(HALF_RC_CYCLES);
      end
    end else if (busy_ff && rc_edge) begin
      nxt_timer = rc_timer_ff - TW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_ff     <= 1'b0;
      rc_timer_ff <= '0;
      op_mode_ff  <= MODE_ATOMIC;
      op_addr_ff  <= '0;
      op_data_ff  <= 8'h00;
    end else if (clk_en) begin
      rc_timer_ff <= nxt_timer;
      if (start_wr) begin
        busy_ff    <= 1'b1;
        op_mode_ff <= wr_mode;
        op_addr_ff <= addr_ff;
        op_data_ff <= data_ff;
      end else if (wr_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // array update at the end of the programming time
  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_done) begin
      unique case (op_mode_ff)
        MODE_ATOMIC: mem[op_addr_ff] <= op_data_ff;
        MODE_ERASE:  mem[op_addr_ff] <= 8'hff;
        MODE_WRITE:  mem[op_addr_ff] <= mem[op_addr_ff] & op_data_ff;
        default:     mem[op_addr_ff] <= mem[op_addr_ff];
      endcase
    end
  end

  // cpu stall after accepted strobes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stall_cnt_ff <= 3'h0;
    end else if (clk_en) begin
      if (start_wr) begin
        stall_cnt_ff <= `EAC_WR_STALL;
      end else if (start_rd) begin
        stall_cnt_ff <= `EAC_RD_STALL;
      end else if (stall_cnt_ff != 3'h0) begin
        stall_cnt_ff <= stall_cnt_ff - 3'h1;
      end
    end
  end

  // read data one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (clk_en) begin
      if (!bus.io_re) begin
        rdata_ff <= 8'h00;
      end else if (hit(bus.io_addr, `EAC_OFS_CTRL)) begin
        // read strobe bit is never stored, so it always returns zero
        rdata_ff <= {2'b00, mode_ff, rie_ff, arm_live, busy_ff, 1'b0};
      end else if (hit(bus.io_addr, `EAC_OFS_DATA)) begin
        rdata_ff <= data_ff;
      end else if (hit(bus.io_addr, `EAC_OFS_ADRL)) begin
        rdata_ff <= addr_ff[7:0];
      end else if (hit(bus.io_addr, `EAC_OFS_ADRH)) begin
        rdata_ff <= 8'(addr_ff[ADDR_W-1:8]);
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign bus.io_rdata  = rdata_ff;
  assign bus.cpu_stall = (stall_cnt_ff != 3'h0);
  assign bus.ready_irq = rie_ff && bus.global_irq_enable && !busy_ff
                         && !bus.flash_selfprog_enable;
  assign nv_busy       = busy_ff;

endmodule

// [logic/eac_if.sv]
// i/o register port between processor side and nonvolatile access block
`timescale 1ns/1ps
interface eac_if;
  logic [5:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_we;
  logic       io_re;
  logic [7:0] io_rdata;
  logic       cpu_stall;
  logic       flash_selfprog_enable;
  logic       global_irq_enable;
  logic       ready_irq;

  modport dev (
    input  io_addr,
    input  io_wdata,
    input  io_we,
    input  io_re,
    output io_rdata,
    output cpu_stall,
    input  flash_selfprog_enable,
    input  global_irq_enable,
    output ready_irq
  );

  modport cpu (
    output io_addr,
    output io_wdata,
    output io_we,
    output io_re,
    input  io_rdata,
    input  cpu_stall,
    output flash_selfprog_enable,
    output global_irq_enable,
    input  ready_irq
  );
endinterface

// [logic/eac_pkg.sv]
// types of the access block: action codes for the device end, sequencer states for the processor end
package eac_pkg;

  typedef enum logic [1:0] {
    MODE_ATOMIC,
    MODE_ERASE,
    MODE_WRITE,
    MODE_RSVD
  } eac_mode_type;

  typedef enum logic [3:0] {
    H_IDLE,
    H_POLL_RD,
    H_POLL_CHK,
    H_ADR_LO,
    H_ADR_HI,
    H_DATA,
    H_ARM,
    H_FIRE,
    H_RSTROBE,
    H_STALL,
    H_GET,
    H_CAP
  } eac_hstate_type;

endpackage

// [logic/eac_regs.svh]
// offsets, field positions, reset values and timing counts of the access block
`ifndef EAC_REGS_SVH
`define EAC_REGS_SVH

// device i/o register offsets
`define EAC_OFS_CTRL       6'h1f
`define EAC_OFS_DATA       6'h20
`define EAC_OFS_ADRL       6'h21
`define EAC_OFS_ADRH       6'h22

// nv_control field positions
`define EAC_BIT_RSTROBE    0
`define EAC_BIT_WSTROBE    1
`define EAC_BIT_ARM        2
`define EAC_BIT_RIE        3
`define EAC_BIT_MODE       4

// reset values
`define EAC_MODE_RST       2'h0
`define EAC_RIE_RST        1'b0

// timing counts in system clock cycles
`define EAC_ARM_CYCLES     3'h4
`define EAC_WR_STALL       3'h2
`define EAC_RD_STALL       3'h4

// programming times in microseconds, and write length in oscillator cycles
`define EAC_T_ATOMIC_US    3400
`define EAC_T_HALF_US      1800
`define EAC_WRITE_RC_CYCLES 26368

// controller register offsets
`define EAC_H_CMD          3'h0
`define EAC_H_ADRL         3'h1
`define EAC_H_ADRH         3'h2
`define EAC_H_WDATA        3'h3
`define EAC_H_STATUS       3'h4
`define EAC_H_CFG          3'h5
`define EAC_H_RDATA        3'h6

// controller field positions
`define EAC_H_BIT_GO_WR    0
`define EAC_H_BIT_GO_RD    1
`define EAC_H_BIT_SELFPROG 0
`define EAC_H_BIT_GIE      1

`endif

// [sim/eac_assertions.sv]
// concurrent checks on the port that joins the processor end and the device end
`timescale 1ns/1ps
`include "eac_regs.svh"

module eac_assertions (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic       io_we,
  input wire logic       io_re,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_stall,
  input wire logic       flash_selfprog_enable,
  input wire logic       global_irq_enable,
  input wire logic       ready_irq,
  input wire logic       nv_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic       ctl_wr;
  logic       ctl_rd;
  logic [2:0] arm_age_ff;

  assign ctl_wr = io_we && io_addr == `EAC_OFS_CTRL;
  assign ctl_rd = io_re && io_addr == `EAC_OFS_CTRL;

  // saturates, so a stale arm never looks fresh again
  always_ff @(posedge sys_clk) begin
    if (reset)
      arm_age_ff <= 3'h0;
    else if (ctl_wr && io_wdata[2] && !io_wdata[1])
      arm_age_ff <= 3'h1;
    else if (arm_age_ff != 3'h0 && arm_age_ff != 3'h7)
      arm_age_ff <= arm_age_ff + 3'h1;
  end

  AST_STROBE_CAUSE: assert property ($rose(nv_busy) |->
    $past(ctl_wr) && $past(io_wdata[1])) else $error("busy rose without a write strobe");
  AST_ARM_WINDOW: assert property ($rose(nv_busy) |->
    $past(arm_age_ff) inside {[1:4]}) else $error("write started outside the arm window");
  AST_NO_SELFPROG_START: assert property ($rose(nv_busy) |->
    !$past(flash_selfprog_enable)) else $error("write started during flash programming");
  AST_BUSY_READS_SET: assert property (ctl_rd && nv_busy |=> io_rdata[1])
    else $error("strobe bit read low while busy");
  AST_WR_STALL: assert property ($rose(nv_busy) |->
    cpu_stall ##1 cpu_stall ##1 !cpu_stall) else $error("write stall not two cycles");
  AST_RD_STALL: assert property (ctl_wr && io_wdata[0] && !io_wdata[1] && !nv_busy
    |=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall not four cycles");
  AST_RSTROBE_ZERO: assert property (ctl_rd |=> !io_rdata[0])
    else $error("read strobe bit read back high");
  AST_READY_IDLE: assert property (ready_irq |-> !nv_busy && global_irq_enable)
    else $error("ready interrupt while busy or disabled");

  COV_WRITE: cover property ($rose(nv_busy));
  COV_READ: cover property (ctl_wr && io_wdata[0] && !nv_busy);
  COV_READY: cover property (ready_irq);
endmodule

// [sim/tb_eeprom_access_control.sv]
// bench: controller and device joined, plus a second device driven directly
`timescale 1ns/1ps
`include "eac_regs.svh"

module tb_eeprom_access_control;
  localparam int RC_N = 8;
  logic       sys_clk;
  logic       reset;
  logic       rc_osc_clk;
  logic [2:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic [7:0] cmd_rdata;
  logic       cmd_we;
  logic       cmd_re;
  logic       nv_busy;
  logic       b_busy;
  logic [7:0] got;
  logic [7:0] old;
  logic [7:0] exp;
  logic [7:0] wd [3] = '{8'ha5, 8'h5a, 8'h3c};
  logic [7:0] arm_v [4] = '{8'h00, 8'h04, 8'h34, 8'h04};
  logic [7:0] stb_v [4] = '{8'h02, 8'h02, 8'h32, 8'h02};
  int         gap [4] = '{0, 3, 0, 2};
  int         busy_len = 0;
  int         busy_base;
  int         n;
  int         bad_count;
  int         checks_done;

  eac_if u_bus ();
  eac_if b_bus ();

  eac_cpu_end u_eac_cpu_end (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_we(cmd_we), .cmd_re(cmd_re),
    .cmd_rdata(cmd_rdata), .bus(u_bus.cpu));
  eac_device_end #(.WRITE_RC_CYCLES(RC_N)) u_eac_device_end (.sys_clk(sys_clk),
    .reset(reset), .clk_en(1'b1), .rc_osc_clk(rc_osc_clk), .nv_busy(nv_busy), .bus(u_bus.dev));
  eac_device_end #(.WRITE_RC_CYCLES(RC_N)) u_eac_device_end_b (.sys_clk(sys_clk),
    .reset(reset), .clk_en(1'b1), .rc_osc_clk(rc_osc_clk), .nv_busy(b_busy), .bus(b_bus.dev));
  eac_assertions u_eac_assertions (.sys_clk(sys_clk), .reset(reset), .io_addr(u_bus.io_addr),
    .io_wdata(u_bus.io_wdata), .io_we(u_bus.io_we), .io_re(u_bus.io_re),
    .io_rdata(u_bus.io_rdata), .cpu_stall(u_bus.cpu_stall),
    .flash_selfprog_enable(u_bus.flash_selfprog_enable),
    .global_irq_enable(u_bus.global_irq_enable), .ready_irq(u_bus.ready_irq), .nv_busy(nv_busy));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // oscillator unrelated in phase to the system clock
  initial begin
    rc_osc_clk = 1'b0;
    forever #65 rc_osc_clk = ~rc_osc_clk;
  end
  always @(posedge sys_clk) if (nv_busy === 1'b1) busy_len <= busy_len + 1;

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmd_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_we    <= 1'b1;
    @(posedge sys_clk);
    cmd_we    <= 1'b0;
  endtask
  task automatic cmd_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cmd_addr <= a;
    cmd_re   <= 1'b1;
    @(posedge sys_clk);
    cmd_re   <= 1'b0;
    #1 d = cmd_rdata;
  endtask
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    b_bus.io_addr  <= a;
    b_bus.io_wdata <= d;
    b_bus.io_we    <= 1'b1;
    @(posedge sys_clk);
    b_bus.io_we    <= 1'b0;
  endtask
  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    b_bus.io_addr <= a;
    b_bus.io_re   <= 1'b1;
    @(posedge sys_clk);
    b_bus.io_re   <= 1'b0;
    #1 d = b_bus.io_rdata;
  endtask
  task automatic wait_done();
    logic [7:0] st;
    st = 8'h00;
    for (int i = 0; i < 300 && !st[1]; i++)
      cmd_rd(`EAC_H_STATUS, st);
    chk("operation done", 8'h02, st & 8'h02);
  endtask
  // called just after the strobe edge has landed
  task automatic stall_run(input int cyc);
    for (int i = 0; i < cyc; i++) begin
      chk("stall high", 8'h01, {7'h0, b_bus.cpu_stall});
      @(posedge sys_clk);
      #1;
    end
    chk("stall low", 8'h00, {7'h0, b_bus.cpu_stall});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    cmd_addr = 3'h0;
    cmd_wdata = 8'h00;
    cmd_we = 1'b0;
    cmd_re = 1'b0;
    b_bus.io_addr = 6'h00;
    b_bus.io_wdata = 8'h00;
    b_bus.io_we = 1'b0;
    b_bus.io_re = 1'b0;
    b_bus.flash_selfprog_enable = 1'b0;
    b_bus.global_irq_enable = 1'b0;
    bad_count = 0;
    checks_done = 0;
    old = 8'h00;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    // every documented action, each read back and timed
    for (int m = 0; m < 3; m++) begin
      cmd_wr(`EAC_H_CFG, {2'h0, 2'(m), 4'h0});
      cmd_wr(`EAC_H_ADRL, 8'h35);
      cmd_wr(`EAC_H_ADRH, 8'h01);
      cmd_wr(`EAC_H_WDATA, wd[m]);
      busy_base = busy_len;
      cmd_wr(`EAC_H_CMD, 8'h01);
      wait_done();
      exp = (m == 0) ? wd[m] : (m == 1) ? 8'hff : (old & wd[m]);
      cmd_wr(`EAC_H_CMD, 8'h02);
      wait_done();
      cmd_rd(`EAC_H_RDATA, got);
      chk("byte read back", exp, got);
      n = (m == 0) ? RC_N : RC_N * 1800 / 3400;
      busy_base = busy_len - busy_base;
      chk("write length", 8'h01,
          {7'h0, busy_base >= (n - 1) * 6 && busy_base <= n * 7 + 3});
      old = exp;
    end
    // flash self-programming holds off the write, ready interrupt when idle
    cmd_wr(`EAC_H_CFG, 8'h0a);
    cmd_wr(`EAC_H_CMD, 8'h01);
    wait_done();
    // controller is done once the stall ends, programming still runs on
    for (int i = 0; i < 400 && nv_busy !== 1'b0; i++)
      @(posedge sys_clk);
    #1 chk("ready irq idle", 8'h01, {7'h0, u_bus.ready_irq});
    cmd_wr(`EAC_H_CFG, 8'h0b);
    cmd_wr(`EAC_H_CMD, 8'h01);
    repeat (30) @(posedge sys_clk);
    #1 chk("busy under selfprog", 8'h00, {7'h0, nv_busy});
    chk("ready irq under selfprog", 8'h00, {7'h0, u_bus.ready_irq});
    cmd_wr(`EAC_H_CFG, 8'h0a);
    wait_done();
    // direct device: address and data first, interrupts never involved
    io_wr(`EAC_OFS_ADRL, 8'h10);
    io_wr(`EAC_OFS_ADRH, 8'h00);
    io_wr(`EAC_OFS_DATA, 8'h77);
    // armed strobe still refused while flash programming is flagged
    b_bus.flash_selfprog_enable <= 1'b1;
    io_wr(`EAC_OFS_CTRL, 8'h04);
    io_wr(`EAC_OFS_CTRL, 8'h02);
    #1 chk("direct busy under selfprog", 8'h00, {7'h0, b_busy});
    @(posedge sys_clk);
    b_bus.flash_selfprog_enable <= 1'b0;
    // no arm, late strobe, reserved action, strobe on the last armed cycle
    for (int k = 0; k < 4; k++) begin
      io_wr(`EAC_OFS_CTRL, arm_v[k]);
      repeat (gap[k]) @(posedge sys_clk);
      io_wr(`EAC_OFS_CTRL, stb_v[k]);
      #1 chk("busy after strobe", {7'h0, k == 3}, {7'h0, b_busy});
    end
    stall_run(2);
    io_wr(`EAC_OFS_ADRL, 8'h55);
    io_wr(`EAC_OFS_DATA, 8'h11);
    io_wr(`EAC_OFS_CTRL, 8'h14);
    io_wr(`EAC_OFS_CTRL, 8'h02);
    io_wr(`EAC_OFS_CTRL, 8'h01);
    #1 chk("read stall while busy", 8'h00, {7'h0, b_bus.cpu_stall});
    io_rd(`EAC_OFS_CTRL, got);
    chk("control while busy", 8'h02, got & 8'h33);
    for (int i = 0; i < 400 && b_busy !== 1'b0; i++)
      @(posedge sys_clk);
    io_rd(`EAC_OFS_CTRL, got);
    chk("control after write", 8'h00, got & 8'h03);
    io_wr(`EAC_OFS_CTRL, 8'h01);
    #1 stall_run(4);
    io_rd(`EAC_OFS_DATA, got);
    chk("byte after direct write", 8'h77, got);
    io_rd(`EAC_OFS_ADRL, got);
    chk("address kept", 8'h10, got);
    complete_run();
  end
endmodule
